/* File: serial_flash_sdr_read_path_tb.sv */
// self-checking bench for the serial flash read path
`timescale 1ns/1ns
`default_nettype none
module serial_flash_sdr_read_path_tb;
  import sfrd_pkg::*;
  typedef struct packed {
    logic [7:0] op; logic [7:0] bank; logic [1:0] lc; logic [31:0] ad;
    logic [2:0] nab; logic [3:0] nd; logic dual; logic [24:0] ea;
  } sfrd_row_s;
  logic clk_sys, rst, clk_en, bank_load, pattern_load, read_active, sck_link, chip_select_n;
  logic [1:0]  latency_code;
  logic [7:0]  bank_wdata, bank_rdata, pattern_wdata, array_rd_data;
  logic        host_si, lane0, lane1, z_out, z_oe, o_out, o_oe;
  logic [24:0] array_rd_addr;
  logic [15:0] rx;
  int          num_errors = 0;
  int          cmp_count = 0;
  // read rows: instruction, bank, latency, address, bytes, dummies, dual, start
  // link clock stays below 50 MHz, so zero-dummy rows may stand; no DDR reads
  sfrd_row_s rows [8] = '{
    '{8'h03, 8'h01, 2'h0, 32'h0012_3456, 3'h3, 4'h0, 1'b0, 25'h112_3456},
    '{8'h13, 8'h01, 2'h0, 32'h00ab_cdef, 3'h4, 4'h0, 1'b0, 25'h0ab_cdef},
    '{8'h03, 8'h80, 2'h0, 32'h01ff_ffff, 3'h4, 4'h0, 1'b0, 25'h1ff_ffff},
    '{8'h0b, 8'h00, 2'h3, 32'h0000_0010, 3'h3, 4'h0, 1'b0, 25'h000_0010},
    '{8'h0b, 8'h00, 2'h0, 32'h0034_5678, 3'h3, 4'h8, 1'b0, 25'h034_5678},
    '{8'h0c, 8'h00, 2'h1, 32'h0100_0001, 3'h4, 4'h8, 1'b0, 25'h100_0001},
    '{8'h3b, 8'h00, 2'h3, 32'h00fe_dcba, 3'h3, 4'h0, 1'b1, 25'h0fe_dcba},
    '{8'h3c, 8'h00, 2'h2, 32'h0102_0304, 3'h4, 4'h8, 1'b1, 25'h102_0304}};
  // lane levels from all drivers; released lane one shows a changing value
  assign lane0 = z_oe ? z_out : host_si;
  assign lane1 = o_oe ? o_out : ~host_si;
  assign array_rd_data = arr_f(array_rd_addr);
  always #10 clk_sys = ~clk_sys;
  sfrd_read_path #(.SMALL_DENSITY(1'b0)) dut_u (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .latency_code(latency_code), .bank_load(bank_load), .bank_wdata(bank_wdata),
    .bank_rdata(bank_rdata), .pattern_load(pattern_load), .pattern_wdata(pattern_wdata),
    .read_active(read_active), .sck_link(sck_link), .chip_select_n(chip_select_n),
    .data_lane_zero_in(lane0), .data_lane_zero_out(z_out), .data_lane_zero_oe(z_oe),
    .data_lane_one_out(o_out), .data_lane_one_oe(o_oe), .array_rd_addr(array_rd_addr),
    .array_rd_data(array_rd_data));
  sfrd_host_model host_u (.sck_link(sck_link), .chip_select_n(chip_select_n),
    .host_si(host_si), .lane_one(lane1), .lane_zero(lane0));
  // array content as a function of address
  function automatic logic [7:0] arr_f(input logic [24:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ {7'h00, a[24]} ^ 8'h3c;
  endfunction
  // two bytes from a start address, wrapping at the top
  function automatic logic [31:0] exp2(input logic [24:0] a);
    return {16'h0000, arr_f(a), arr_f(a + 25'h000_0001)};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // load bank, latency and pattern while deselected
  task automatic cfg(input logic [7:0] bk, input logic [1:0] lc, input logic [7:0] pt);
    @(negedge clk_sys);
    bank_load = 1'b1;
    bank_wdata = bk;
    pattern_load = 1'b1;
    pattern_wdata = pt;
    latency_code = lc;
    @(negedge clk_sys);
    bank_load = 1'b0;
    pattern_load = 1'b0;
    chk({24'h000000, bank_rdata}, {24'h000000, bk});
  endtask
  task automatic end_sim();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    latency_code = 2'h0;
    bank_load = 1'b0;
    bank_wdata = 8'h00;
    pattern_load = 1'b0;
    pattern_wdata = 8'h00;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    foreach (rows[k]) begin
      cfg(rows[k].bank, rows[k].lc, 8'ha5);
      host_u.xfer(rows[k].op, rows[k].ad, rows[k].nab, rows[k].nd, 16 >> rows[k].dual,
                  rows[k].dual, rx);
      chk({16'h0000, rx}, exp2(rows[k].ea));
    end
    // training pattern repeated over two bytes
    cfg(8'h00, 2'h0, 8'h96);
    host_u.xfer(8'h41, 32'h0000_0000, 0, 0, 16, 1'b0, rx);
    chk({16'h0000, rx}, 32'h0000_9696);
    // unknown instruction stays silent
    host_u.xfer(8'h9f, 32'h0000_0000, 3, 0, 16, 1'b0, rx);
    // deselect in mid byte, then a clean read
    host_u.xfer(8'h0b, 32'h0000_0100, 3, 8, 5, 1'b0, rx);
    chk({30'h0000_0000, o_oe, z_oe}, 32'h0000_0000);
    host_u.xfer(8'h0b, rows[4].ad, 3, 8, 16, 1'b0, rx);
    chk({16'h0000, rx}, exp2(rows[4].ea));
    // load while frozen is refused
    @(negedge clk_sys);
    clk_en = 1'b0;
    bank_load = 1'b1;
    bank_wdata = 8'h55;
    @(negedge clk_sys);
    bank_load = 1'b0;
    clk_en = 1'b1;
    chk({24'h000000, bank_rdata}, 32'h0000_0000);
    // second reset clears the bank register
    cfg(8'h83, 2'h1, 8'h3c);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({23'h000000, read_active, bank_rdata}, 32'h0000_0000);
    rst = 1'b0;
    host_u.xfer(8'h03, 32'h00ab_0001, 3, 0, 16, 1'b0, rx);
    chk({16'h0000, rx}, exp2(25'h0ab_0001));
    end_sim();
  end
  // watchdog against a hang
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire

/* File: sfrd_host_model.sv */
// host serial master model for the read path link
`timescale 1ns/1ns
`default_nettype none
module sfrd_host_model (
  output var logic  sck_link,      // link clock, still low between frames
  output var logic  chip_select_n, // select, active low
  output var logic  host_si,       // host drive of lane zero
  input  wire logic lane_one,      // lane one level
  input  wire logic lane_zero      // lane zero level
);
  // idle levels
  initial begin
    sck_link = 1'b0;
    chip_select_n = 1'b1;
    host_si = 1'b0;
  end
  // one frame: instruction, address, dummies, data clocks
  task automatic xfer(input logic [7:0] op, input logic [31:0] ad, input int nab, input int nd,
                      input int nc, input bit dual, output logic [15:0] rx);
    logic [39:0] sh;
    int          nh;
    sh = (nab == 3) ? {op, ad[23:0], 8'h00} : {op, ad};
    nh = 8 + 8 * nab;
    rx = 16'h0000;
    #5 chip_select_n = 1'b0;
    for (int i = 0; i < nh + nd + nc; i++) begin
      if (i < nh) begin // msb first, one bit a rise
        host_si = sh[39];
        sh = sh << 1;
      end else begin // released lane toggles
        host_si = ~host_si;
      end
      #24 sck_link = 1'b1;
      if (i >= nh + nd) begin // capture data on rise
        rx = dual ? {rx[13:0], lane_one, lane_zero} : {rx[14:0], lane_one};
      end
      #24 sck_link = 1'b0;
    end
    #5 chip_select_n = 1'b1; // held low through dummies unless aborting
    #40;
  endtask
endmodule
`default_nettype wire

/* File: sfrd_pkg.sv */
// constants, states and carriers shared by the serial flash read path
package sfrd_pkg;

  // read instruction codes, array and training pattern
  localparam logic [7:0] OP_READ3  = 8'h03;  // normal read, 3 or 4 byte address
  localparam logic [7:0] OP_READ4  = 8'h13;  // normal_read_wide_address
  localparam logic [7:0] OP_FAST3  = 8'h0b;  // quick read, 3 or 4 byte address
  localparam logic [7:0] OP_FAST4  = 8'h0c;  // quick_read_wide_address
  localparam logic [7:0] OP_DUAL3  = 8'h3b;  // two_bit_output_read
  localparam logic [7:0] OP_DUAL4  = 8'h3c;  // two_bit_output_read_wide_address
  localparam logic [7:0] OP_TRAIN  = 8'h41;  // training_pattern_read_cmd

  // bit counter end values, counted on rising edges of the link clock
  localparam logic [5:0] CNT_CMD_LAST    = 6'h07;  // 8 instruction bits
  localparam logic [5:0] CNT_ADDR3_LAST  = 6'h17;  // 24 address bits
  localparam logic [5:0] CNT_ADDR4_LAST  = 6'h1f;  // 32 address bits
  localparam logic [5:0] CNT_DUMMY_LAST  = 6'h07;  // 8 dummy cycles
  localparam logic [5:0] CNT_BYTE1_LAST  = 6'h07;  // 8 clocks per byte, one lane
  localparam logic [5:0] CNT_BYTE2_LAST  = 6'h03;  // 4 clocks per byte, two lanes

  // field positions and widths
  localparam int       EXT_BIT   = 7;    // four_byte_addr_flag inside the bank register
  localparam int       ARRAY_AW  = 25;   // array address width, larger density
  localparam logic [31:0] MASK_FULL  = 32'h01ff_ffff;  // 32 MB array
  localparam logic [31:0] MASK_SMALL = 32'h00ff_ffff;  // 16 MB array, A23 and below

  // latency_code value that selects zero dummy cycles
  localparam logic [1:0] LC_NO_DUMMY = 2'h3;

  // values after reset
  localparam logic [7:0] BANK_RESET    = 8'h00;
  localparam logic [7:0] PATTERN_RESET = 8'h00;
  localparam logic [1:0] LC_RESET      = 2'h0;
  localparam logic [5:0] CNT_RESET     = 6'h00;
  localparam logic [31:0] ADDR_RESET   = 32'h0000_0000;

  // link state machine
  typedef enum logic [2:0] {
    ST_CMD    = 3'b000,  // taking the instruction
    ST_ADDR   = 3'b001,  // taking the address
    ST_DUMMY  = 3'b010,  // dummy cycles, inputs ignored
    ST_DATA   = 3'b011,  // array data out
    ST_TRAIN  = 3'b100,  // training pattern out
    ST_IGNORE = 3'b101   // unknown instruction, wait for deselect
  } sfrd_state_e;

  // configuration handed from the system clock to the link clock
  typedef struct packed {
    logic [7:0] bank;      // bank address register, bit 7 is the four-byte flag
    logic [1:0] lc;        // latency_code of config_register_one
    logic [7:0] pattern;   // training_pattern
  } sfrd_cfg_s;

  // properties of the decoded read
  typedef struct packed {
    logic four_byte;  // address is 32 bits
    logic dummy;      // dummy cycles follow the address
    logic dual;       // two data lanes
  } sfrd_cmd_s;

endpackage

/* File: sfrd_read_path.sv */
// serial flash single-data-rate read path, device side
`timescale 1ns/1ns
`default_nettype none
module sfrd_read_path
  import sfrd_pkg::*;
#(
  parameter bit SMALL_DENSITY = 1'b0  // 1 selects the 16 MB variant
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                clk_en,
  input  wire logic [1:0]          latency_code,
  input  wire logic                bank_load,
  input  wire logic [7:0]          bank_wdata,
  output logic      [7:0]          bank_rdata,
  input  wire logic                pattern_load,
  input  wire logic [7:0]          pattern_wdata,
  output logic                     read_active,
  input  wire logic                sck_link,
  input  wire logic                chip_select_n,
  input  wire logic                data_lane_zero_in,
  output logic                     data_lane_zero_out,
  output logic                     data_lane_zero_oe,
  output logic                     data_lane_one_out,
  output logic                     data_lane_one_oe,
  output logic      [ARRAY_AW-1:0] array_rd_addr,
  input  wire logic [7:0]          array_rd_data
);

  // ---------------------------------------------------------------
  // system clock domain: configuration registers
  // ---------------------------------------------------------------
  logic [7:0]  bank_r;      // bank address register
  logic [7:0]  bank_nxt;
  logic [7:0]  pat_r;       // training pattern
  logic [7:0]  pat_nxt;
  logic [1:0]  lc_r;        // latency code
  logic [1:0]  lc_nxt;
  sfrd_cfg_s   cfg_sys;     // bundle towards the link clock
  sfrd_cfg_s   cfg_link;    // same bundle after the synchroniser
  logic        busy_sys;    // read activity seen on the system clock
  logic        busy_r;      // data or pattern phase reached, link clock

  // next values of the configuration registers
  always_comb begin
    bank_nxt = bank_r;
    pat_nxt  = pat_r;
    lc_nxt   = latency_code;  // follows the configuration register field
    if (bank_load) begin
      bank_nxt = bank_wdata;  // load command for the bank register
    end
    if (pattern_load) begin
      pat_nxt = pattern_wdata;
    end
  end

  // configuration registers, frozen while clk_en is low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bank_r <= BANK_RESET;  // bank defaults to zero
      pat_r  <= PATTERN_RESET;
      lc_r   <= LC_RESET;
    end else if (clk_en) begin
      bank_r <= bank_nxt;
      pat_r  <= pat_nxt;
      lc_r   <= lc_nxt;
    end
  end

  assign cfg_sys    = '{bank: bank_r, lc: lc_r, pattern: pat_r};
  assign bank_rdata = bank_r;  // read command for the bank register

  // activity level back into the system domain
  sfrd_sync #(
    .W (1)
  ) u_busy_sync (
    .clk (clk_sys),
    .rst (rst),
    .en  (clk_en),
    .d   (busy_r),
    .q   (busy_sys)
  );
  assign read_active = busy_sys;

  // ---------------------------------------------------------------
  // link clock domain
  // ---------------------------------------------------------------
  logic        link_rst;    // deselect or system reset ends every frame
  sfrd_state_e state_r;     // link state
  sfrd_state_e state_nxt;
  logic [5:0]  cnt_r;       // bit, dummy and byte counter
  logic [5:0]  cnt_nxt;
  logic [6:0]  sh_r;        // instruction shifter
  logic [6:0]  sh_nxt;
  logic [31:0] addr_r;      // address shifter, then read pointer
  logic [31:0] addr_nxt;
  sfrd_cmd_s   cmd_r;       // decoded read kind
  sfrd_cmd_s   cmd_nxt;
  logic        busy_nxt;
  logic [7:0]  op;          // completed instruction
  logic [31:0] addr_full;   // address including the bit on the pin
  logic [31:0] addr_mask;   // density dependent address mask
  logic        ext_eff;     // four-byte flag as this density sees it
  logic        dummy_eff;   // latency code asks for dummy cycles
  logic [5:0]  addr_last;   // last address bit count
  logic [5:0]  byte_last;   // last clock of a data byte

  assign link_rst = rst | chip_select_n;  // deselect stops the command

  // configuration follows into the link domain; stable well before
  // the eight instruction clocks have passed
  sfrd_sync #(
    .W ($bits(sfrd_cfg_s))
  ) u_cfg_sync (
    .clk (sck_link),
    .rst (rst),
    .en  (1'b1),
    .d   (cfg_sys),
    .q   (cfg_link)
  );

  // small variant ignores the flag, the bank and bits above A23
  assign addr_mask = SMALL_DENSITY ? MASK_SMALL : MASK_FULL;
  assign ext_eff   = cfg_link.bank[EXT_BIT] & ~SMALL_DENSITY;
  assign dummy_eff = (cfg_link.lc != LC_NO_DUMMY);  // zero or eight dummies
  assign op        = {sh_r, data_lane_zero_in};
  assign addr_full = {addr_r[30:0], data_lane_zero_in};
  assign addr_last = cmd_r.four_byte ? CNT_ADDR4_LAST : CNT_ADDR3_LAST;
  assign byte_last = cmd_r.dual ? CNT_BYTE2_LAST : CNT_BYTE1_LAST;

  // next state of the rising-edge link logic
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = 6'(cnt_r + 6'h01);
    sh_nxt    = sh_r;
    addr_nxt  = addr_r;
    cmd_nxt   = cmd_r;
    busy_nxt  = busy_r;
    case (state_r)
      ST_CMD: begin
        // instruction one bit per rising edge on the single line
        sh_nxt = op[6:0];
        if (cnt_r == CNT_CMD_LAST) begin
          cnt_nxt   = CNT_RESET;
          state_nxt = ST_ADDR;
          // only plain SDR reads decode; no mode bits, no DDR
          case (op)
            OP_READ3: begin
              cmd_nxt = '{four_byte: ext_eff, dummy: 1'b0, dual: 1'b0};
            end
            OP_READ4: begin
              cmd_nxt = '{four_byte: 1'b1, dummy: 1'b0, dual: 1'b0};
            end
            OP_FAST3: begin
              cmd_nxt = '{four_byte: ext_eff, dummy: dummy_eff, dual: 1'b0};
            end
            OP_FAST4: begin
              cmd_nxt = '{four_byte: 1'b1, dummy: dummy_eff, dual: 1'b0};
            end
            OP_DUAL3: begin
              cmd_nxt = '{four_byte: ext_eff, dummy: dummy_eff, dual: 1'b1};
            end
            OP_DUAL4: begin
              cmd_nxt = '{four_byte: 1'b1, dummy: dummy_eff, dual: 1'b1};
            end
            OP_TRAIN: begin
              state_nxt = ST_TRAIN;  // pattern follows the instruction
              busy_nxt  = 1'b1;
            end
            default: begin
              state_nxt = ST_IGNORE;  // not a read of this path
            end
          endcase
        end
      end
      ST_ADDR: begin
        // address sampled on rising edges only
        addr_nxt = addr_full;
        if (cnt_r == addr_last) begin
          cnt_nxt = CNT_RESET;
          if (cmd_r.four_byte) begin
            addr_nxt = addr_full & addr_mask;
          end else begin
            addr_nxt = {cfg_link.bank, addr_full[23:0]} & addr_mask;  // bank supplies top
          end
          if (cmd_r.dummy) begin
            state_nxt = ST_DUMMY;
          end else begin
            state_nxt = ST_DATA;  // data on the very next falling edge
            busy_nxt  = 1'b1;
          end
        end
      end
      ST_DUMMY: begin
        // eight falling-to-falling cycles, pin values unused
        if (cnt_r == CNT_DUMMY_LAST) begin
          cnt_nxt   = CNT_RESET;
          state_nxt = ST_DATA;
          busy_nxt  = 1'b1;
        end
      end
      ST_DATA: begin
        // next byte after the last clock of this one, wrapping to zero
        if (cnt_r == byte_last) begin
          cnt_nxt  = CNT_RESET;
          addr_nxt = 32'(addr_r + 32'h0000_0001) & addr_mask;
        end
      end
      ST_TRAIN: begin
        // same pattern again for every eight clocks
        if (cnt_r == CNT_BYTE1_LAST) begin
          cnt_nxt = CNT_RESET;
        end
      end
      default: begin
        cnt_nxt = cnt_r;  // unknown instruction, hold until deselect
      end
    endcase
  end

  // rising-edge link registers, cleared whenever chip select is high
  always_ff @(posedge sck_link or posedge link_rst) begin
    if (link_rst) begin
      state_r <= ST_CMD;
      cnt_r   <= CNT_RESET;
      sh_r    <= 7'h00;
      addr_r  <= ADDR_RESET;
      cmd_r   <= '0;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      addr_r  <= addr_nxt;
      cmd_r   <= cmd_nxt;
      busy_r  <= busy_nxt;
    end
  end

  assign array_rd_addr = addr_r[ARRAY_AW-1:0];

  // ---------------------------------------------------------------
  // falling-edge output stage
  // ---------------------------------------------------------------
  logic [7:0] out_byte;   // byte being shifted out
  logic [2:0] out_shift;  // bits already sent in this byte
  logic [7:0] out_word;   // byte aligned so the next bit is at the top
  logic       lane0_nxt;
  logic       lane0_oe_nxt;
  logic       lane1_nxt;
  logic       lane1_oe_nxt;

  // next pin values; drive only in data or pattern phase
  always_comb begin
    lane0_nxt    = 1'b0;
    lane0_oe_nxt = 1'b0;
    lane1_nxt    = 1'b0;
    lane1_oe_nxt = 1'b0;
    out_byte  = (state_r == ST_TRAIN) ? cfg_link.pattern : array_rd_data;
    out_shift = (cmd_r.dual && state_r == ST_DATA) ? {cnt_r[1:0], 1'b0} : cnt_r[2:0];
    out_word  = out_byte << out_shift;
    if (state_r == ST_TRAIN) begin
      lane1_nxt    = out_word[7];  // pattern msb first on SO
      lane1_oe_nxt = 1'b1;
    end else if (state_r == ST_DATA) begin
      lane1_nxt    = out_word[7];  // one new bit per falling edge
      lane1_oe_nxt = 1'b1;
      if (cmd_r.dual) begin
        lane0_nxt    = out_word[6];  // second bit on the other lane
        lane0_oe_nxt = 1'b1;
      end
    end
  end

  // output registers, released at once on deselect
  always_ff @(negedge sck_link or posedge link_rst) begin
    if (link_rst) begin
      data_lane_zero_out <= 1'b0;
      data_lane_zero_oe  <= 1'b0;
      data_lane_one_out  <= 1'b0;
      data_lane_one_oe   <= 1'b0;
    end else begin
      data_lane_zero_out <= lane0_nxt;
      data_lane_zero_oe  <= lane0_oe_nxt;
      data_lane_one_out  <= lane1_nxt;
      data_lane_one_oe   <= lane1_oe_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: sfrd_read_path_monitor.sv */
// port checker for the serial flash read path
`timescale 1ns/1ns
`default_nettype none
module sfrd_read_path_monitor (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic [1:0] latency_code,
  input wire logic       bank_load,
  input wire logic [7:0] bank_wdata,
  input wire logic [7:0] bank_rdata,
  input wire logic       read_active,
  input wire logic       sck_link,
  input wire logic       chip_select_n,
  input wire logic       data_lane_zero_in,
  input wire logic       data_lane_zero_oe,
  input wire logic       data_lane_one_oe
);
  logic [6:0] rise_cnt;   // link rises in this frame
  logic [7:0] op_r;       // instruction seen on lane zero
  logic [6:0] first_rise; // last rise before data
  logic       is_rd;      // array read decoded
  logic       is_dual;    // two lane read
  logic       wide;       // four byte address
  logic       dly;        // eight dummy cycles
  // frame counter, cleared by deselect
  always_ff @(posedge sck_link or posedge chip_select_n) begin
    if (chip_select_n) begin
      rise_cnt <= 7'h00;
      op_r     <= 8'h00;
    end else begin
      if (rise_cnt != 7'h7f) begin
        rise_cnt <= rise_cnt + 7'h01;
      end
      if (rise_cnt < 7'h08) begin
        op_r <= {op_r[6:0], data_lane_zero_in};
      end
    end
  end
  // expected start of data per instruction
  always_comb begin
    is_dual = (op_r == 8'h3b) || (op_r == 8'h3c);
    wide = (op_r == 8'h13) || (op_r == 8'h0c) || (op_r == 8'h3c) || bank_rdata[7];
    dly = ((op_r == 8'h0b) || (op_r == 8'h0c) || is_dual) && (latency_code != 2'h3);
    is_rd = (op_r == 8'h03) || (op_r == 8'h13) || (op_r == 8'h0b) || (op_r == 8'h0c) || is_dual;
    first_rise = (wide ? 7'h28 : 7'h20) + (dly ? 7'h08 : 7'h00);
  end
  chk_oe_deselect: assert property (@(posedge clk_sys) disable iff (rst)
    chip_select_n |-> !data_lane_one_oe && !data_lane_zero_oe)
    else $error("lanes driven while deselected");
  chk_bank_load: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && bank_load |=> bank_rdata == $past(bank_wdata))
    else $error("bank register load lost");
  chk_bank_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !(clk_en && bank_load) |=> $stable(bank_rdata))
    else $error("bank register changed without load");
  chk_active_idle: assert property (@(posedge clk_sys) disable iff (rst)
    (chip_select_n && clk_en) [*3] |=> !read_active)
    else $error("read active while idle");
  chk_active_busy: assert property (@(posedge clk_sys) disable iff (rst)
    (!chip_select_n && data_lane_one_oe && clk_en) [*3] |=> read_active)
    else $error("read active missing in data phase");
  chk_instr_first: assert property (@(negedge sck_link) disable iff (chip_select_n)
    data_lane_one_oe |-> rise_cnt > 7'h08)
    else $error("output before instruction complete");
  chk_train_start: assert property (@(negedge sck_link) disable iff (chip_select_n)
    op_r == 8'h41 && rise_cnt > 7'h08 |-> data_lane_one_oe && !data_lane_zero_oe)
    else $error("training pattern not driven");
  chk_data_start: assert property (@(negedge sck_link) disable iff (chip_select_n)
    is_rd && !is_dual && rise_cnt > 7'h08 |->
      data_lane_one_oe == (rise_cnt > first_rise) && !data_lane_zero_oe)
    else $error("single lane data start wrong");
  chk_dual_start: assert property (@(negedge sck_link) disable iff (chip_select_n)
    is_dual && rise_cnt > 7'h08 |->
      data_lane_zero_oe == (rise_cnt > first_rise) && data_lane_zero_oe == data_lane_one_oe)
    else $error("dual lane data start wrong");
  chk_unknown_quiet: assert property (@(negedge sck_link) disable iff (chip_select_n)
    !is_rd && op_r != 8'h41 && rise_cnt > 7'h08 |-> !data_lane_one_oe && !data_lane_zero_oe)
    else $error("output on unknown instruction");
  cov_train: cover property (@(negedge sck_link) op_r == 8'h41 && data_lane_one_oe);
  cov_dual: cover property (@(negedge sck_link) data_lane_zero_oe);
  cov_flag: cover property (@(posedge clk_sys) clk_en && bank_load && bank_wdata[7]);
endmodule
bind sfrd_read_path sfrd_read_path_monitor mon_u (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
  .latency_code(latency_code), .bank_load(bank_load), .bank_wdata(bank_wdata),
  .bank_rdata(bank_rdata), .read_active(read_active), .sck_link(sck_link),
  .chip_select_n(chip_select_n), .data_lane_zero_in(data_lane_zero_in),
  .data_lane_zero_oe(data_lane_zero_oe), .data_lane_one_oe(data_lane_one_oe));
`default_nettype wire

/* File: sfrd_sync.sv */
// two flip-flop synchroniser for quasi-static levels
`timescale 1ns/1ns
`default_nettype none
module sfrd_sync #(
  parameter int W = 1  // width of the level bundle
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;  // first stage, read only by the second

  // two stages, frozen together while en is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else if (en) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule
`default_nettype wire
